// ===== tb/test_timer_event_counter.sv
`include "timer_cfg.svh"
module test_timer_event_counter;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, r, r0;
    logic        neighbor_a_group_timer_ovf_in = 1'b0, b_group_third_timer_ovf_in = 1'b0;
    logic        level = 1'b0, dir_up = 1'b0, err, t0;
    wire  [31:0] prdata_out;
    wire         pready_out, pslverr_out, timer_output_pin_out, timer_output_pin_oe_out, interrupt_request_out;
    wire         timer_input_pin_in, timer_output_pin_in, slow_clock_tick_in;
    int          num_errors = 0, check_count = 0, irq_count = 0, n, i0;
    int          gaps [4] = '{2, 16, 64, 32};
    logic [11:0] ev_mode [5] = '{12'h805, 12'h501, 12'h821, 12'h201, 12'hC01};
    logic [15:0] ev_load [5] = '{16'hFFFE, 16'h0002, 16'hFFFF, 16'h0005, 16'hFFFD};
    logic [15:0] ev_cnt [5] = '{16'hFFFF, 16'h0002, 16'h0001, 16'h0003, 16'hFFFF};
    int          ev_k [5] = '{3, 3, 2, 1, 2};
    int          ev_irq [5] = '{1, 1, 1, 0, 0};
    timer_event_counter dut (.*);
    timer_pins_model pins (.pin_level_in(level), .dir_up_in(dir_up), .pin_out_in(timer_output_pin_out),
        .pin_oe_in(timer_output_pin_oe_out), .input_pin_out(timer_input_pin_in),
        .pin_wire_out(timer_output_pin_in), .slow_tick_out(slow_clock_tick_in));
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) if (interrupt_request_out === 1'b1) irq_count <= irq_count + 1;
    ////////////////////////////////////////////////////////////////
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one transfer, then one idle cycle so the next setup never reuses this edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        // no cycle count assumed: only the watchdog ends a wait that never answers
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        r = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clock_in);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task irq_gap;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (interrupt_request_out !== 1'b1 && n < 3000);
    endtask : irq_gap
    task pulses(input int k);
        repeat (k) begin
            level <= 1'b1;
            repeat (4) @(posedge clock_in);
            level <= 1'b0;
            repeat (4) @(posedge clock_in);
        end
        repeat (4) @(posedge clock_in);
    endtask : pulses
    task ovf(input int k);
        repeat (k) begin
            neighbor_a_group_timer_ovf_in <= 1'b1;
            @(posedge clock_in);
            neighbor_a_group_timer_ovf_in <= 1'b0;
            b_group_third_timer_ovf_in <= 1'b1;
            @(posedge clock_in);
            b_group_third_timer_ovf_in <= 1'b0;
            @(posedge clock_in);
        end
    endtask : ovf
    task give_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        rd(`ADDR_COUNTER);
        check("count reset", r, 32'h0);
        rd(`ADDR_MODE);
        check("mode reset", r, 32'h0);
        rd(12'h040);
        check("unmapped error", {31'h0, err}, 32'h1);
        // every prescaled source with reload 1 gives two ticks per wrap
        wr(`ADDR_COUNTER, 32'h1);
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_MODE, s << 6);
            wr(`ADDR_COUNT_START, 32'h1);
            irq_gap();
            irq_gap();
            check("source period", n, gaps[s]);
            wr(`ADDR_COUNT_START, 32'h0);
        end
        wr(`ADDR_MODE, 32'h0);
        wr(`ADDR_COUNTER, 32'h5);
        rd(`ADDR_COUNTER);
        check("stopped load", r, 32'h5);
        wr(`ADDR_COUNT_START, 32'h1);
        irq_gap();
        irq_gap();
        check("period n+1", n, 6);
        wr(`ADDR_COUNTER, 32'h9);
        irq_gap();
        irq_gap();
        check("running reload", n, 10);
        wr(`ADDR_MODE, 32'h4);
        irq_gap();
        @(posedge clock_in);
        t0 = timer_output_pin_out;
        irq_gap();
        @(posedge clock_in);
        check("pulse toggle", timer_output_pin_out, {31'h0, ~t0});
        wr(`ADDR_COUNT_START, 32'h0);
        rd(`ADDR_COUNTER);
        r0 = r;
        repeat (30) @(posedge clock_in);
        rd(`ADDR_COUNTER);
        check("stopped hold", r, r0);
        // gate active high, held low first
        wr(`ADDR_MODE, 32'h18);
        wr(`ADDR_COUNT_START, 32'h1);
        rd(`ADDR_COUNTER);
        r0 = r;
        repeat (20) @(posedge clock_in);
        rd(`ADDR_COUNTER);
        check("gate closed", r, r0);
        level <= 1'b1;
        repeat (20) @(posedge clock_in);
        rd(`ADDR_COUNTER);
        check("gate open", r !== r0, 32'h1);
        level <= 1'b0;
        // event rows: up, external down on falling edges, free run, neighbour, external up
        for (int s = 0; s < 5; s++) begin
            wr(`ADDR_COUNT_START, 32'h0);
            dir_up <= ev_mode[s][11];
            wr(`ADDR_MODE, ev_mode[s]);
            wr(`ADDR_COUNTER, ev_load[s]);
            i0 = irq_count;
            wr(`ADDR_COUNT_START, 32'h1);
            if (ev_mode[s][9])
                ovf(ev_k[s]);
            else
                pulses(ev_k[s]);
            rd(`ADDR_COUNTER);
            check("event count", r, ev_cnt[s]);
            check("event requests", irq_count - i0, ev_irq[s]);
        end
        wr(`ADDR_MODE, 32'h0);
        wr(`ADDR_CONTROL, 32'h3);
        check("port drive", {timer_output_pin_oe_out, timer_output_pin_out}, 32'h3);
        give_verdict();
    end
endmodule : test_timer_event_counter

// ===== tb/timer_event_counter_checker.sv
`include "timer_cfg.svh"
module timer_event_counter_checker (
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        timer_output_pin_out,
    input wire logic        timer_output_pin_oe_out,
    input wire logic        interrupt_request_out
);
    logic        start_reg;  // shadow of the count start flag
    logic [11:0] mode_reg;   // shadow of the mode word
    logic [1:0]  port_reg;   // shadow of port level and drive
    logic [15:0] load_reg;   // last value written while stopped
    logic        fresh_reg;  // counter still holds load_reg
    wire wr_acc = psel_in && penable_in && pwrite_in;
    wire rd_acc = psel_in && penable_in && !pwrite_in;
    wire ext_dir = (mode_reg[1:0] == 2'b01) && mode_reg[10];
    wire pulse_on = mode_reg[2] && !ext_dir;
    ////////////////////////////////////////////////////////////////
    // shadows follow completed writes; the counter is only known while stopped
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            start_reg <= 1'b0;
            mode_reg  <= 12'h000;
            port_reg  <= 2'h0;
            load_reg  <= 16'h0000;
            fresh_reg <= 1'b1;
        end else if (wr_acc) begin
            case (paddr_in)
                `ADDR_COUNT_START: begin
                    start_reg <= pwdata_in[0];
                    fresh_reg <= fresh_reg && !pwdata_in[0];
                end
                `ADDR_MODE: mode_reg <= pwdata_in[11:0];
                `ADDR_CONTROL: port_reg <= pwdata_in[1:0];
                `ADDR_COUNTER: if (!start_reg) begin
                    load_reg  <= pwdata_in[15:0];
                    fresh_reg <= 1'b1;
                end
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    property p_start_read;
        rd_acc && paddr_in == `ADDR_COUNT_START |-> prdata_out == {31'h0, start_reg};
    endproperty
    a_start_read: assert property (p_start_read) else $error("start flag read wrong");
    property p_mode_read;
        rd_acc && paddr_in == `ADDR_MODE |-> prdata_out == {20'h0, mode_reg};
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read wrong");
    property p_count_read;
        rd_acc && paddr_in == `ADDR_COUNTER && fresh_reg |-> prdata_out == {16'h0, load_reg};
    endproperty
    a_count_read: assert property (p_count_read) else $error("stopped load not read back");
    // one cycle of slack: a wrap at the stopping edge may still report
    property p_stop_quiet;
        !start_reg && !$past(start_reg) |-> !interrupt_request_out;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("request while stopped");
    property p_pulse_oe;
        pulse_on |-> timer_output_pin_oe_out;
    endproperty
    a_pulse_oe: assert property (p_pulse_oe) else $error("pulse pin not driven");
    property p_dir_in;
        ext_dir |-> !timer_output_pin_oe_out;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("direction pin driven");
    property p_port;
        !mode_reg[2] && !ext_dir |-> {timer_output_pin_oe_out, timer_output_pin_out} == port_reg;
    endproperty
    a_port: assert property (p_port) else $error("port pin mismatch");
    property p_toggle;
        pulse_on && $past(pulse_on) && $changed(timer_output_pin_out) |-> ##[0:1] interrupt_request_out;
    endproperty
    a_toggle: assert property (p_toggle) else $error("pin toggled without wrap");
    c_fresh: cover property (rd_acc && paddr_in == `ADDR_COUNTER && fresh_reg);
    c_pulse: cover property (pulse_on && interrupt_request_out);
    c_dir:   cover property (ext_dir && start_reg);
endmodule : timer_event_counter_checker
bind timer_event_counter timer_event_counter_checker chk (.*);

// ===== tb/timer_pins_model.sv
module timer_pins_model (
    input  wire logic pin_level_in,   // level asked of the input pin
    input  wire logic dir_up_in,      // direction the outside world applies
    input  wire logic pin_out_in,
    input  wire logic pin_oe_in,
    output wire logic input_pin_out,
    output wire logic pin_wire_out,
    output logic      slow_tick_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // count edges and gate level come straight from the stimulus
    assign input_pin_out = pin_level_in;
    // the direction level only reaches the wire while the block lets go of it
    assign pin_wire_out = pin_oe_in ? pin_out_in : dir_up_in;
    // slow source, offset from the system clock so sampling never races
    initial begin
        slow_tick_out = 1'b0;
        #3;
        forever #80 slow_tick_out = ~slow_tick_out;
    end
endmodule : timer_pins_model

// ===== verilog/timer_cfg.svh
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// register byte offsets
`define ADDR_COUNT_START  12'h000
`define ADDR_MODE         12'h004
`define ADDR_COUNTER      12'h008
`define ADDR_CONTROL      12'h00C
`define ADDR_STATUS       12'h010

// mode register fields
`define MODE_LSB          0
`define MODE_MSB          1
`define MODE_PULSE_BIT    2
`define MODE_GATE_EN_BIT  3
`define MODE_GATE_LVL_BIT 4
`define MODE_FREE_RUN_BIT 5
`define MODE_SRC_LSB      6
`define MODE_SRC_MSB      7
`define MODE_EDGE_BIT     8
`define MODE_EVT_SRC_BIT  9
`define MODE_DIR_EXT_BIT  10
`define MODE_DIR_SW_BIT   11
`define MODE_WIDTH        12

// prescaler divisions for three of the four clock sources
`define DIV_F8            8
`define DIV_F32           32
`define DIV_FSLOW         128

// reset values
`define RESET_COUNT       16'h0000
`define RESET_MODE        12'h000

`endif

// ===== verilog/timer_event_counter.sv
`include "timer_cfg.svh"
// Behaviour
// [R1] 16-bit counter with 16-bit reload register
// [R2] mode chosen by two low mode bits
// [R3] timer mode counts one of four prescaled clocks
// [R4] timer counts down, reloads on underflow
// [R5] start flag starts and stops counting
// [R6] timer mode interrupt on each underflow
// [R7] counter read returns current count
// [R8] stopped write loads reload and counter
// [R9] running write loads reload only
// [R10] gate pin level starts and stops timer
// [R11] timer pulse output toggles on underflow
// [R12] single-phase event counting on every channel
// [R13] events: pin edges or neighbour overflow
// [R14] direction by software or external input
// [R15] event mode reloads on over/underflow
// [R16] free-run wraps without reloading
// [R17] event mode interrupt on over/underflow
// [R18] event pulse output toggles on over/underflow
// [R19] output pin is port, pulse or direction
// [R20] gated ticks count only while gate active
module timer_event_counter
    import timer_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [11:0]       paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              timer_input_pin_in,
    input  wire logic              timer_output_pin_in,
    input  wire logic              neighbor_a_group_timer_ovf_in,
    input  wire logic              b_group_third_timer_ovf_in,
    input  wire logic              slow_clock_tick_in,
    output logic                   timer_output_pin_out,
    output logic                   timer_output_pin_oe_out,
    output logic                   interrupt_request_out
);

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [WIDTH-1:0]       counter_reg;        // live count
    logic [WIDTH-1:0]       reload_reg;         // reload value
    logic                   start_reg;          // count start flag
    logic [`MODE_WIDTH-1:0] mode_reg;           // mode register
    logic                   port_level_reg;     // general port output level
    logic                   port_dir_reg;       // general port drives pin
    logic                   pulse_reg;          // toggling pulse output
    logic                   irq_reg;            // one-cycle interrupt request
    logic                   in_sync1_reg;       // input pin, first stage
    logic                   in_sync2_reg;       // input pin, synchronised
    logic                   in_prev_reg;        // previous synchronised input
    logic                   out_sync1_reg;      // direction pin, first stage
    logic                   out_sync2_reg;      // direction pin, synchronised
    logic                   slow_sync1_reg;     // slow clock, first stage
    logic                   slow_sync2_reg;     // slow clock, synchronised
    logic                   slow_prev_reg;      // previous slow clock level
    logic [4:0]             prescale_reg;       // free-running prescaler
    logic [31:0]            prdata_reg;         // registered read data

    ////////////////////////////////////////////////////////////////////////
    // decoded mode fields
    // plain slices of the mode word; mode codes 2 and 3 never tick
    timer_mode_e            mode;
    logic [1:0]             source_sel;
    logic                   pulse_en;
    logic                   gate_en;
    logic                   gate_level;
    logic                   free_run;
    logic                   edge_falling;
    logic                   event_from_timer;
    logic                   dir_external;
    logic                   dir_up_sw;

    assign mode             = timer_mode_e'(mode_reg[`MODE_MSB:`MODE_LSB]); // [R2]
    assign source_sel       = mode_reg[`MODE_SRC_MSB:`MODE_SRC_LSB];
    assign pulse_en         = mode_reg[`MODE_PULSE_BIT];
    assign gate_en          = mode_reg[`MODE_GATE_EN_BIT];
    assign gate_level       = mode_reg[`MODE_GATE_LVL_BIT];
    assign free_run         = mode_reg[`MODE_FREE_RUN_BIT];
    assign edge_falling     = mode_reg[`MODE_EDGE_BIT];
    assign event_from_timer = mode_reg[`MODE_EVT_SRC_BIT];
    assign dir_external     = mode_reg[`MODE_DIR_EXT_BIT];
    assign dir_up_sw        = mode_reg[`MODE_DIR_SW_BIT];

    ////////////////////////////////////////////////////////////////////////
    // APB slave decode: zero wait states, unmapped reads zero with error
    // pready is tied high: every register answers in the first access cycle
    logic apb_access;
    logic apb_write;
    logic addr_hit;

    assign apb_access  = psel_in & penable_in;
    assign apb_write   = apb_access & pwrite_in;
    assign pready_out  = 1'b1;
    assign addr_hit    = (paddr_in == `ADDR_COUNT_START) | (paddr_in == `ADDR_MODE) |
                         (paddr_in == `ADDR_COUNTER) | (paddr_in == `ADDR_CONTROL) |
                         (paddr_in == `ADDR_STATUS);
    assign pslverr_out = apb_access & ~addr_hit;
    assign prdata_out  = prdata_reg;

    // read data is prepared in the setup cycle so it is stable in access
    // the snapshot costs a register but keeps a live mux off the access phase
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel_in & ~penable_in & ~pwrite_in) begin
            unique case (paddr_in)
                `ADDR_COUNT_START: prdata_reg <= {31'h0000_0000, start_reg};
                `ADDR_MODE:        prdata_reg <= {20'h0_0000, mode_reg};
                `ADDR_COUNTER:     prdata_reg <= {16'h0000, counter_reg}; // [R7]
                `ADDR_CONTROL:     prdata_reg <= {30'h0000_0000, port_dir_reg, port_level_reg};
                `ADDR_STATUS:      prdata_reg <= {30'h0000_0000, in_sync2_reg, timer_output_pin_out};
                default:           prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software control registers
    // a write to an unmapped offset touches nothing; only pslverr reports it
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            start_reg      <= 1'b0;
            mode_reg       <= `RESET_MODE;
            port_level_reg <= 1'b0;
            port_dir_reg   <= 1'b0;
        end else if (apb_write) begin
            if (paddr_in == `ADDR_COUNT_START) begin
                start_reg <= pwdata_in[0];  // [R5]
            end
            if (paddr_in == `ADDR_MODE) begin
                mode_reg <= pwdata_in[`MODE_WIDTH-1:0];
            end
            if (paddr_in == `ADDR_CONTROL) begin
                port_level_reg <= pwdata_in[0];
                port_dir_reg   <= pwdata_in[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    // edge history resets low, so an idle-low pin gives no false edge after reset
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            in_sync1_reg   <= 1'b0;
            in_sync2_reg   <= 1'b0;
            in_prev_reg    <= 1'b0;
            out_sync1_reg  <= 1'b0;
            out_sync2_reg  <= 1'b0;
            slow_sync1_reg <= 1'b0;
            slow_sync2_reg <= 1'b0;
            slow_prev_reg  <= 1'b0;
        end else begin
            in_sync1_reg   <= timer_input_pin_in;
            in_sync2_reg   <= in_sync1_reg;
            in_prev_reg    <= in_sync2_reg;
            out_sync1_reg  <= timer_output_pin_in;
            out_sync2_reg  <= out_sync1_reg;
            slow_sync1_reg <= slow_clock_tick_in;
            slow_sync2_reg <= slow_sync1_reg;
            slow_prev_reg  <= slow_sync2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler: one free counter serves the divide-by-8 and divide-by-32 taps
    // it never stops, so the first prescaled tick after start may come early
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            prescale_reg <= 5'h00;
        end else begin
            prescale_reg <= prescale_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tick selection
    logic timer_tick;
    logic pin_edge;
    logic event_tick;
    logic gate_open;
    logic count_up;
    logic tick;

    // source choice among four prescaled clocks
    // the slow source counts rising edges of an outside clock, already synchronised
    always_comb begin
        unique case (source_sel)  // [R3]
            2'b00: timer_tick = 1'b1;
            2'b01: timer_tick = (prescale_reg[2:0] == 3'(`DIV_F8 - 1));
            2'b10: timer_tick = (prescale_reg[4:0] == 5'(`DIV_F32 - 1));
            2'b11: timer_tick = slow_sync2_reg & ~slow_prev_reg;
        endcase
    end

    // chosen edge of the input pin, or a neighbour overflow
    assign pin_edge   = edge_falling ? (in_prev_reg & ~in_sync2_reg)
                                     : (~in_prev_reg & in_sync2_reg);
    assign event_tick = event_from_timer ? (neighbor_a_group_timer_ovf_in | b_group_third_timer_ovf_in)
                                         : pin_edge;  // [R12] [R13]
    // gate qualifies each timer-mode tick with the pin level; event ticks ignore it
    assign gate_open  = ~gate_en | (in_sync2_reg == gate_level);  // [R10] [R20]
    // up when direction pin or software bit says so
    assign count_up   = dir_external ? out_sync2_reg : dir_up_sw;  // [R14]

    always_comb begin
        unique case (mode)
            MODE_TIMER:   tick = start_reg & timer_tick & gate_open;  // [R5] [R20]
            MODE_EVENT:   tick = start_reg & event_tick;              // [R5]
            default:      tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // wrap detection
    // a tick that finds the counter at its end value wraps instead of stepping
    logic             is_event;
    logic             going_up;
    logic             wrap;
    logic             do_reload;

    assign is_event  = (mode == MODE_EVENT);
    assign going_up  = is_event & count_up;
    assign wrap      = tick & (going_up ? (counter_reg == 16'hFFFF) : (counter_reg == 16'h0000));
    // free-run only applies in event counter mode
    assign do_reload = wrap & ~(is_event & free_run);  // [R4] [R15] [R16]

    ////////////////////////////////////////////////////////////////////////
    // counter and reload register
    logic cnt_write;
    assign cnt_write = apb_write & (paddr_in == `ADDR_COUNTER);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            reload_reg <= `RESET_COUNT;
        end else if (cnt_write) begin
            reload_reg <= pwdata_in[WIDTH-1:0];  // [R1] [R8] [R9]
        end
    end

    // a write while stopped lands in the counter too; while running only on reload
    // a running write never disturbs the live count, so a period in flight ends as set
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            counter_reg <= `RESET_COUNT;
        end else if (cnt_write & ~start_reg) begin
            counter_reg <= pwdata_in[WIDTH-1:0];  // [R8]
        end else if (do_reload) begin
            counter_reg <= reload_reg;  // [R4] [R9] [R15]
        end else if (tick) begin
            // wrap in free-run falls out of the 16-bit arithmetic
            counter_reg <= going_up ? counter_reg + 16'h0001 : counter_reg - 16'h0001;  // [R1] [R16]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt request and pulse output
    // both follow the wrap by one edge, so pin and request change together
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            irq_reg   <= 1'b0;
            pulse_reg <= 1'b0;
        end else begin
            irq_reg <= wrap;  // [R6] [R17]
            if (wrap & pulse_en) begin
                pulse_reg <= ~pulse_reg;  // [R11] [R18]
            end
        end
    end

    assign interrupt_request_out = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // output pin: pulse output, direction input, or general port
    // direction input wins over pulse output so the pin is never driven against the outside
    logic pin_is_dir_input;
    assign pin_is_dir_input = is_event & dir_external;

    always_comb begin
        if (pulse_en & ~pin_is_dir_input) begin  // [R19]
            timer_output_pin_out    = pulse_reg;
            timer_output_pin_oe_out = 1'b1;
        end else if (pin_is_dir_input) begin
            // pin is released so the outside can steer the direction
            timer_output_pin_out    = 1'b0;
            timer_output_pin_oe_out = 1'b0;
        end else begin
            timer_output_pin_out    = port_level_reg;
            timer_output_pin_oe_out = port_dir_reg;
        end
    end

endmodule : timer_event_counter

// ===== verilog/timer_pkg.sv
package timer_pkg;
    // operating mode field encoding
    typedef enum logic [1:0] {
        MODE_TIMER   = 2'b00,
        MODE_EVENT   = 2'b01,
        MODE_ONESHOT = 2'b10,
        MODE_PWM     = 2'b11
    } timer_mode_e;
endpackage : timer_pkg
